// ### plp_pkg.sv
package plp_pkg;
  localparam int          PORT_W          = 8;
  localparam logic [7:0]  LATCH_RST       = 8'hFF;
  localparam int          STRONG_PU_NS    = 20;
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          STRONG_PU_CYC   = (STRONG_PU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0]  STRONG_CNT_W1   = 2'h1;
endpackage

// ### plp_port_io.sv
`timescale 1ns/100ps
module plp_port_io #(
  parameter int W = plp_pkg::PORT_W
) (
  input  wire logic         CORE_CLK,
  input  wire logic         SYS_RST,
  input  wire logic         CLK_EN,
  input  wire logic [W-1:0] BUS_WDATA,
  input  wire logic [W-1:0] BUS_WMASK,
  input  wire logic         WR_FIRST,
  input  wire logic         WR_SECOND,
  input  wire logic         RD_LATCH,
  input  wire logic         RD_PIN,
  input  wire logic         RD_SECOND,
  output logic [W-1:0]      BUS_RDATA,
  input  wire logic         EXT_MEM_ACT,
  input  wire logic [W-1:0] EXT_ADDR_DATA,
  input  wire logic [W-1:0] FIRST_PIN_I,
  output logic [W-1:0]      FIRST_PIN_O,
  output logic [W-1:0]      FIRST_PIN_OE,
  input  wire logic [W-1:0] SECOND_PIN_I,
  output logic [W-1:0]      SECOND_PIN_O,
  output logic [W-1:0]      SECOND_PIN_OE,
  output logic [1:0]        STRONG_PULLUP,
  output logic [1:0]        HOLDING_PULLUP,
  output logic [1:0]        WEAK_KEEPER,
  input  wire logic         PULSE_A_EN,
  input  wire logic         PULSE_B_EN,
  input  wire logic         PULSE_OUTPUT_A,
  input  wire logic         PULSE_OUTPUT_B,
  output logic              TIMER2_COUNT_INPUT,
  output logic              TIMER2_TRIGGER_INPUT,
  input  wire logic         TWO_WIRE_MASTER_SELECT,
  input  wire logic         MASTER_CLOCK_OUT_BIT,
  input  wire logic         MASTER_DATA_OUT_BIT,
  input  wire logic         MASTER_DATA_DRIVE_ENABLE,
  input  wire logic         SPI_ENABLE,
  input  wire logic         SPI_MASTER,
  input  wire logic         SPI_SCLK_OUT,
  input  wire logic         SPI_MOSI_OUT,
  input  wire logic         SPI_MISO_OUT,
  input  wire logic         SERIAL_CLOCK_PIN_I,
  input  wire logic         SERIAL_DATA_PIN_I,
  input  wire logic         MISO_PIN_I,
  output logic              SERIAL_CLOCK_PIN_O,
  output logic              SERIAL_CLOCK_PIN_OE,
  output logic              SERIAL_DATA_PIN_O,
  output logic              SERIAL_DATA_PIN_OE,
  output logic              MISO_PIN_O,
  output logic              MISO_PIN_OE,
  output logic              MASTER_DATA_IN_BIT,
  output logic              SLAVE_SELECT_PULLUP
);
  if (W != 8) begin : g_chk
    $error("plp_port_io: port width must be 8");
  end
  if (plp_pkg::STRONG_PU_CYC < 1 || plp_pkg::STRONG_PU_CYC > 3) begin : g_cnt_chk
    $error("plp_port_io: strong pull-up length must fit the 2-bit counter");
  end

  logic [W-1:0] first_latch_r;
  logic [W-1:0] second_latch_r;
  logic [W-1:0] first_sync1_r, first_sync2_r;
  logic [W-1:0] second_sync1_r, second_sync2_r;
  logic [2:0]   ser_sync1_r, ser_sync2_r;
  logic [1:0]   second_prev_r;
  logic [1:0]   strong_cnt_r [2];
  logic [1:0]   pulse_en;
  logic [1:0]   pulse_val;

  assign pulse_en  = {PULSE_B_EN, PULSE_A_EN};
  assign pulse_val = {PULSE_OUTPUT_B, PULSE_OUTPUT_A};

  // Pins are asynchronous to the core
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      first_sync1_r  <= '0;
      first_sync2_r  <= '0;
      second_sync1_r <= '0;
      second_sync2_r <= '0;
      ser_sync1_r    <= '0;
      ser_sync2_r    <= '0;
    end else if (CLK_EN) begin
      first_sync1_r  <= FIRST_PIN_I;
      first_sync2_r  <= first_sync1_r;
      second_sync1_r <= SECOND_PIN_I;
      second_sync2_r <= second_sync1_r;
      ser_sync1_r    <= {MISO_PIN_I, SERIAL_DATA_PIN_I, SERIAL_CLOCK_PIN_I};
      ser_sync2_r    <= ser_sync1_r;
    end
  end

  // Core merges the modified bit into a whole byte; mask picks written bits
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      first_latch_r <= plp_pkg::LATCH_RST;
    end else if (CLK_EN) begin
      if (EXT_MEM_ACT) begin
        first_latch_r <= plp_pkg::LATCH_RST;
      end else if (WR_FIRST) begin
        first_latch_r <= (first_latch_r & ~BUS_WMASK) | (BUS_WDATA & BUS_WMASK);
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      second_latch_r <= plp_pkg::LATCH_RST;
    end else if (CLK_EN && WR_SECOND) begin
      second_latch_r <= (second_latch_r & ~BUS_WMASK) | (BUS_WDATA & BUS_WMASK);
    end
  end

  // Read path: read-modify-write cycles ask for the latch, others the pin
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      BUS_RDATA <= '0;
    end else if (CLK_EN) begin
      if (RD_LATCH) begin
        BUS_RDATA <= RD_SECOND ? second_latch_r : first_latch_r;
      end else if (RD_PIN) begin
        BUS_RDATA <= RD_SECOND ? second_sync2_r : first_sync2_r;
      end
    end
  end

  // First port drivers
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      FIRST_PIN_O  <= '0;
      FIRST_PIN_OE <= '0;
    end else if (CLK_EN) begin
      if (EXT_MEM_ACT) begin
        FIRST_PIN_O  <= EXT_ADDR_DATA;
        FIRST_PIN_OE <= '1;
      end else begin
        FIRST_PIN_O  <= '0;
        FIRST_PIN_OE <= ~first_latch_r;
      end
    end
  end

  // Strong pull-up one-shot on a latch rise of the two low pins
  for (genvar i = 0; i < 2; i++) begin : g_low
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        strong_cnt_r[i] <= '0;
      end else if (CLK_EN) begin
        if (second_latch_r[i] && !second_prev_r[i]) begin
          // Rise cycle drives the first strong cycle itself, so count only the rest
          strong_cnt_r[i] <= 2'(plp_pkg::STRONG_PU_CYC) - plp_pkg::STRONG_CNT_W1;
        end else if (strong_cnt_r[i] != '0) begin
          strong_cnt_r[i] <= strong_cnt_r[i] - plp_pkg::STRONG_CNT_W1;
        end
      end
    end

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        SECOND_PIN_O[i]   <= 1'b1;
        SECOND_PIN_OE[i]  <= 1'b0;
        STRONG_PULLUP[i]  <= 1'b0;
        HOLDING_PULLUP[i] <= 1'b0;
        WEAK_KEEPER[i]    <= 1'b0;
      end else if (CLK_EN) begin
        if (pulse_en[i]) begin
          SECOND_PIN_O[i]   <= pulse_val[i];
          SECOND_PIN_OE[i]  <= 1'b1;
          STRONG_PULLUP[i]  <= 1'b0;
          HOLDING_PULLUP[i] <= 1'b0;
          WEAK_KEEPER[i]    <= 1'b0;
        end else begin
          SECOND_PIN_O[i]   <= 1'b0;
          SECOND_PIN_OE[i]  <= ~second_latch_r[i];
          STRONG_PULLUP[i]  <= second_latch_r[i] && (strong_cnt_r[i] != '0 ||
                               (second_latch_r[i] && !second_prev_r[i]));
          HOLDING_PULLUP[i] <= second_latch_r[i] && second_sync2_r[i];
          WEAK_KEEPER[i]    <= second_latch_r[i];
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      second_prev_r <= plp_pkg::LATCH_RST[1:0];
    end else if (CLK_EN) begin
      second_prev_r <= second_latch_r[1:0];
    end
  end

  // Upper second-port pins: plain quasi-bidirectional behaviour
  for (genvar j = 2; j < W; j++) begin : g_high
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        SECOND_PIN_O[j]  <= 1'b0;
        SECOND_PIN_OE[j] <= 1'b0;
      end else if (CLK_EN) begin
        SECOND_PIN_O[j]  <= 1'b0;
        SECOND_PIN_OE[j] <= ~second_latch_r[j];
      end
    end
  end

  // Timer-2 inputs see zero unless the latch is one
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      TIMER2_COUNT_INPUT   <= 1'b0;
      TIMER2_TRIGGER_INPUT <= 1'b0;
    end else if (CLK_EN) begin
      TIMER2_COUNT_INPUT   <= second_latch_r[0] & second_sync2_r[0];
      TIMER2_TRIGGER_INPUT <= second_latch_r[1] & second_sync2_r[1];
    end
  end

  // Serial pins: SPI when enabled, else software two-wire master when selected, else all released
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      SERIAL_CLOCK_PIN_O  <= 1'b1;
      SERIAL_CLOCK_PIN_OE <= 1'b0;
      SERIAL_DATA_PIN_O   <= 1'b1;
      SERIAL_DATA_PIN_OE  <= 1'b0;
      MISO_PIN_O          <= 1'b1;
      MISO_PIN_OE         <= 1'b0;
      MASTER_DATA_IN_BIT  <= 1'b1;
      SLAVE_SELECT_PULLUP <= 1'b1;
    end else if (CLK_EN) begin
      SLAVE_SELECT_PULLUP <= 1'b1;
      if (SPI_ENABLE) begin
        SERIAL_CLOCK_PIN_O  <= SPI_SCLK_OUT;
        SERIAL_CLOCK_PIN_OE <= SPI_MASTER;
        SERIAL_DATA_PIN_O   <= SPI_MOSI_OUT;
        SERIAL_DATA_PIN_OE  <= SPI_MASTER;
        MISO_PIN_O          <= SPI_MISO_OUT;
        MISO_PIN_OE         <= ~SPI_MASTER;
      end else if (TWO_WIRE_MASTER_SELECT) begin
        SERIAL_CLOCK_PIN_O  <= MASTER_CLOCK_OUT_BIT;
        SERIAL_CLOCK_PIN_OE <= 1'b1;
        SERIAL_DATA_PIN_O   <= MASTER_DATA_OUT_BIT;
        SERIAL_DATA_PIN_OE  <= MASTER_DATA_DRIVE_ENABLE;
        MISO_PIN_OE         <= 1'b0;
        if (!MASTER_DATA_DRIVE_ENABLE) begin
          MASTER_DATA_IN_BIT <= ser_sync2_r[1];
        end
      end else begin
        SERIAL_CLOCK_PIN_OE <= 1'b0;
        SERIAL_DATA_PIN_OE  <= 1'b0;
        MISO_PIN_OE         <= 1'b0;
      end
    end
  end

  rst_latch_a: assert property (@(posedge CORE_CLK) $fell(SYS_RST) |-> first_latch_r == plp_pkg::LATCH_RST)
    else $error("latch not one after reset");
  ext_ones_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && EXT_MEM_ACT |=> first_latch_r == plp_pkg::LATCH_RST)
    else $error("external access did not set latch");
  ext_drive_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && EXT_MEM_ACT |=> FIRST_PIN_OE == '1 && FIRST_PIN_O == $past(EXT_ADDR_DATA))
    else $error("first port not push-pull on address/data");
  od_drive_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && !EXT_MEM_ACT |=> FIRST_PIN_OE == ~$past(first_latch_r) && FIRST_PIN_O == '0)
    else $error("open-drain drive wrong");
  rd_latch_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && RD_LATCH && !RD_SECOND |=> BUS_RDATA == $past(first_latch_r))
    else $error("read latch returned wrong value");
  rd_second_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && RD_LATCH && RD_SECOND |=> BUS_RDATA == $past(second_latch_r))
    else $error("second port latch read wrong");
  rd_pin_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && RD_PIN && !RD_LATCH && !RD_SECOND |=> BUS_RDATA == $past(first_sync2_r))
    else $error("read pin returned wrong value");
  strong_len_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && !PULSE_A_EN && second_latch_r[0] && !second_prev_r[0] ##1 CLK_EN && !PULSE_A_EN
    |-> STRONG_PULLUP[0] ##1 (!CLK_EN || PULSE_A_EN || STRONG_PULLUP[0]))
    else $error("strong pull-up too short");
  // Catches a one-shot that runs a cycle long
  strong_end_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && second_latch_r[0] && !second_prev_r[0] ##1 CLK_EN && second_latch_r[0] ##1 CLK_EN && second_latch_r[0]
    |=> !STRONG_PULLUP[0])
    else $error("strong pull-up too long");
  low_drive_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && !PULSE_A_EN && !second_latch_r[0] |=> SECOND_PIN_OE[0] && !SECOND_PIN_O[0])
    else $error("low pin not driven low");
  hold_drop_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && !PULSE_A_EN && !second_sync2_r[0] |=> !HOLDING_PULLUP[0] && WEAK_KEEPER[0] == $past(second_latch_r[0]))
    else $error("holding pull-up not dropped");
  pulse_ovr_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && PULSE_A_EN |=> SECOND_PIN_OE[0] && SECOND_PIN_O[0] == $past(PULSE_OUTPUT_A))
    else $error("pulse did not override latch");
  tw_clock_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && !SPI_ENABLE && TWO_WIRE_MASTER_SELECT |=> SERIAL_CLOCK_PIN_O == $past(MASTER_CLOCK_OUT_BIT) &&
    SERIAL_DATA_PIN_OE == $past(MASTER_DATA_DRIVE_ENABLE))
    else $error("two-wire master pins wrong");
  miso_role_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && SPI_ENABLE |=> MISO_PIN_OE == !$past(SPI_MASTER) && SERIAL_DATA_PIN_OE == $past(SPI_MASTER))
    else $error("serial data roles wrong");
  ss_pullup_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN |=> SLAVE_SELECT_PULLUP)
    else $error("slave-select pull-up off");
  t2_gate_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    CLK_EN && !second_latch_r[0] |=> !TIMER2_COUNT_INPUT)
    else $error("timer input not held at zero");

  ext_cycle_c: cover property (@(posedge CORE_CLK) disable iff (SYS_RST) EXT_MEM_ACT ##1 !EXT_MEM_ACT);
  strong_c: cover property (@(posedge CORE_CLK) disable iff (SYS_RST) STRONG_PULLUP[0]);
  rmw_c: cover property (@(posedge CORE_CLK) disable iff (SYS_RST) RD_LATCH ##1 WR_FIRST);
  tw_c: cover property (@(posedge CORE_CLK) disable iff (SYS_RST) TWO_WIRE_MASTER_SELECT && SERIAL_DATA_PIN_OE);
endmodule // plp_port_io

// ### plp_pin_model.sv
`timescale 1ns/100ps
module plp_pin_model (
  input  wire logic [7:0] FIRST_PIN_O,
  input  wire logic [7:0] FIRST_PIN_OE,
  input  wire logic [7:0] SECOND_PIN_O,
  input  wire logic [7:0] SECOND_PIN_OE,
  input  wire logic       SERIAL_CLOCK_PIN_O,
  input  wire logic       SERIAL_CLOCK_PIN_OE,
  input  wire logic       SERIAL_DATA_PIN_O,
  input  wire logic       SERIAL_DATA_PIN_OE,
  input  wire logic       MISO_PIN_O,
  input  wire logic       MISO_PIN_OE,
  input  wire logic [7:0] pull_first,
  input  wire logic [7:0] pull_second,
  output logic [7:0]      FIRST_PIN_I,
  output logic [7:0]      SECOND_PIN_I,
  output logic            SERIAL_CLOCK_PIN_I,
  output logic            SERIAL_DATA_PIN_I,
  output logic            MISO_PIN_I
);
  // Board pull-ups hold released lines high unless a device pulls them low
  assign FIRST_PIN_I  = (FIRST_PIN_OE & FIRST_PIN_O) | (~FIRST_PIN_OE & ~pull_first);
  assign SECOND_PIN_I = (SECOND_PIN_OE & SECOND_PIN_O) | (~SECOND_PIN_OE & ~pull_second);
  assign SERIAL_CLOCK_PIN_I = SERIAL_CLOCK_PIN_OE ? SERIAL_CLOCK_PIN_O : 1'b1;
  assign SERIAL_DATA_PIN_I  = SERIAL_DATA_PIN_OE ? SERIAL_DATA_PIN_O : 1'b1;
  assign MISO_PIN_I         = MISO_PIN_OE ? MISO_PIN_O : 1'b1;
endmodule // plp_pin_model

// ### port_latch_and_pin_io_tb.sv
`timescale 1ns/100ps
module port_latch_and_pin_io_tb;
  logic CORE_CLK = 1'b0;
  logic SYS_RST, CLK_EN, WR_FIRST, WR_SECOND, RD_LATCH, RD_PIN, RD_SECOND, EXT_MEM_ACT;
  logic PULSE_A_EN, PULSE_B_EN, PULSE_OUTPUT_A, PULSE_OUTPUT_B, TWO_WIRE_MASTER_SELECT;
  logic MASTER_CLOCK_OUT_BIT, MASTER_DATA_OUT_BIT, MASTER_DATA_DRIVE_ENABLE;
  logic SPI_ENABLE, SPI_MASTER, SPI_SCLK_OUT, SPI_MOSI_OUT, SPI_MISO_OUT;
  logic TIMER2_COUNT_INPUT, TIMER2_TRIGGER_INPUT, SERIAL_CLOCK_PIN_I, SERIAL_DATA_PIN_I, MISO_PIN_I;
  logic SERIAL_CLOCK_PIN_O, SERIAL_CLOCK_PIN_OE, SERIAL_DATA_PIN_O, SERIAL_DATA_PIN_OE;
  logic MISO_PIN_O, MISO_PIN_OE, MASTER_DATA_IN_BIT, SLAVE_SELECT_PULLUP;
  logic [7:0] BUS_WDATA, BUS_WMASK, BUS_RDATA, EXT_ADDR_DATA, FIRST_PIN_I, FIRST_PIN_O, FIRST_PIN_OE;
  logic [7:0] SECOND_PIN_I, SECOND_PIN_O, SECOND_PIN_OE, pull_first, pull_second, n;
  logic [1:0] STRONG_PULLUP, HOLDING_PULLUP, WEAK_KEEPER;
  int         miscompares, samples_checked, cycles;
  // Rows: write data, write mask, expected latch
  logic [23:0] rows [6] = '{24'h00FF00, 24'hA5FFA5, 24'hFF02A7, 24'h008027, 24'h5AFF5A, 24'hFFFFFF};

  plp_port_io dut (.*);
  plp_pin_model pins (.*);

  always #5 CORE_CLK = ~CORE_CLK;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic w(input int k);
    repeat (k) @(negedge CORE_CLK);
  endtask

  task automatic wr(input logic sec, input logic [7:0] d, input logic [7:0] m);
    @(negedge CORE_CLK);
    WR_FIRST = ~sec;
    WR_SECOND = sec;
    BUS_WDATA = d;
    BUS_WMASK = m;
    @(negedge CORE_CLK);
    WR_FIRST = 1'b0;
    WR_SECOND = 1'b0;
  endtask

  // Read latch or pins of one port and compare the registered answer
  task automatic rc(input logic lat, input logic sec, input logic [7:0] exp);
    @(negedge CORE_CLK);
    RD_LATCH = lat;
    RD_PIN = ~lat;
    RD_SECOND = sec;
    @(negedge CORE_CLK);
    RD_LATCH = 1'b0;
    RD_PIN = 1'b0;
    chk(BUS_RDATA, exp);
  endtask

  initial begin
    {WR_FIRST, WR_SECOND, RD_LATCH, RD_PIN, RD_SECOND, EXT_MEM_ACT, PULSE_A_EN, PULSE_B_EN,
     PULSE_OUTPUT_A, PULSE_OUTPUT_B, TWO_WIRE_MASTER_SELECT, MASTER_CLOCK_OUT_BIT, MASTER_DATA_OUT_BIT,
     MASTER_DATA_DRIVE_ENABLE, SPI_ENABLE, SPI_MASTER, SPI_SCLK_OUT, SPI_MOSI_OUT, SPI_MISO_OUT} = '0;
    {BUS_WDATA, BUS_WMASK, EXT_ADDR_DATA, pull_first, pull_second} = '0;
    SYS_RST = 1'b1;
    CLK_EN = 1'b1;
    w(20);
    chk(FIRST_PIN_OE, 8'h00);
    SYS_RST = 1'b0;
    rc(1'b1, 1'b0, 8'hFF);
    rc(1'b1, 1'b1, 8'hFF);
    chk(8'(SLAVE_SELECT_PULLUP), 8'h01);
    for (int i = 0; i < 6; i++) begin
      wr(1'b0, rows[i][23:16], rows[i][15:8]);
      rc(1'b1, 1'b0, rows[i][7:0]);
      w(2);
      chk(FIRST_PIN_OE, ~rows[i][7:0]);
      w(3);
      rc(1'b0, 1'b0, rows[i][7:0]);
    end
    // Frozen clock enable must swallow a write
    CLK_EN = 1'b0;
    wr(1'b0, 8'h00, 8'hFF);
    CLK_EN = 1'b1;
    rc(1'b1, 1'b0, 8'hFF);
    wr(1'b0, 8'h00, 8'hFF);
    EXT_MEM_ACT = 1'b1;
    EXT_ADDR_DATA = 8'hA5;
    wr(1'b0, 8'h3C, 8'hFF);
    w(3);
    chk(FIRST_PIN_OE, 8'hFF);
    chk(FIRST_PIN_O, 8'hA5);
    rc(1'b0, 1'b0, 8'hA5);
    EXT_MEM_ACT = 1'b0;
    rc(1'b1, 1'b0, 8'hFF);
    wr(1'b1, 8'h00, 8'hFF);
    w(2);
    chk(8'({SECOND_PIN_OE[1:0], SECOND_PIN_O[1:0]}), 8'h0C);
    wr(1'b1, 8'hFF, 8'hFF);
    n = 8'h00;
    repeat (8) begin
      if (STRONG_PULLUP[0] === 1'b1)
        n++;
      @(negedge CORE_CLK);
    end
    chk(n, 8'(plp_pkg::STRONG_PU_CYC));
    chk(8'({HOLDING_PULLUP[0], SECOND_PIN_OE[0], TIMER2_COUNT_INPUT, TIMER2_TRIGGER_INPUT}), 8'h0B);
    pull_second = 8'h01;
    w(5);
    chk(8'({HOLDING_PULLUP[0], WEAK_KEEPER[0], TIMER2_COUNT_INPUT}), 8'h02);
    rc(1'b0, 1'b1, 8'hFE);
    rc(1'b1, 1'b1, 8'hFF);
    pull_second = 8'h00;
    PULSE_A_EN = 1'b1;
    PULSE_B_EN = 1'b1;
    w(3);
    chk(8'(SECOND_PIN_I[1:0]), 8'h00);
    wr(1'b1, 8'h00, 8'hFF);
    PULSE_OUTPUT_A = 1'b1;
    PULSE_OUTPUT_B = 1'b1;
    w(3);
    chk(8'(SECOND_PIN_I[1:0]), 8'h03);
    TWO_WIRE_MASTER_SELECT = 1'b1;
    MASTER_DATA_DRIVE_ENABLE = 1'b1;
    for (int v = 0; v < 2; v++) begin
      MASTER_CLOCK_OUT_BIT = v[0];
      MASTER_DATA_OUT_BIT = ~v[0];
      w(2);
      chk(8'({SERIAL_CLOCK_PIN_I, SERIAL_DATA_PIN_I}), 8'({v[0], ~v[0]}));
    end
    MASTER_DATA_DRIVE_ENABLE = 1'b0;
    w(4);
    chk(8'({SERIAL_DATA_PIN_OE, MASTER_DATA_IN_BIT}), 8'h01);
    // Slave role drives its reply onto the shared input pin
    SPI_ENABLE = 1'b1;
    w(2);
    chk(8'(MISO_PIN_I), 8'h00);
    // Mid-run reset after a zero write must restore both latches
    wr(1'b0, 8'h00, 8'hFF);
    SYS_RST = 1'b1;
    w(2);
    chk(FIRST_PIN_OE, 8'h00);
    SYS_RST = 1'b0;
    rc(1'b1, 1'b0, 8'hFF);
    rc(1'b1, 1'b1, 8'hFF);
    print_verdict();
  end
endmodule // port_latch_and_pin_io_tb
